// >>> umcls_top.sv
// Modem-control and line-status logic of a UART
// Assumes one 100 MHz clock; events and levels from the UART core arrive
// on this clock, modem and serial pins arrive asynchronously
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Loop bit holds serial out high and feeds transmitter into receiver.
// - In loop-back, modem status bit 4 shows the DTR control bit.
// - In loop-back, modem status bit 5 shows the RTS control bit.
// - In loop-back, modem status bit 6 follows the loop ring value.
// - In loop-back, modem status bit 7 follows the loop carrier value.
// - Control bit 4 drives the DTR pin low when set.
// - Control bit 5 drives the RTS pin low when set.
// - DTR and RTS bits ignored under auto flow control or RS-485.
// - RS-485 enable selects RS-485; receiver enable bit matters only then.
// - Receive DMA halts while any error flag is set.
// - Overrun sets status bit 0 and the status interrupt.
// - Parity error sets status bit 1 and the status interrupt.
// - Framing error sets status bit 2 and the status interrupt.
// - Break sets status bit 3 and the status interrupt.
// - Error flags clear only by writing one; zero leaves them.
// - Bit 4 shows receive data held and raises receive interrupt.
// - Bit 5 shows transmit register empty, resets to one.
// - Bit 6 shows transmitter fully idle, resets to one.
module umcls_top (
   input wire logic clk,
   input wire logic nrst,
   // AXI4-Lite register port
   input wire logic awvalid,
   output var logic awready,
   input wire logic [17:0] awaddr,
   input wire logic wvalid,
   output var logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output var logic bvalid,
   input wire logic bready,
   output var logic [1:0] bresp,
   input wire logic arvalid,
   output var logic arready,
   input wire logic [17:0] araddr,
   output var logic rvalid,
   input wire logic rready,
   output var logic [31:0] rdata,
   output var logic [1:0] rresp,
   // Serial and modem pins
   input wire logic sin,
   output var logic sout,
   input wire logic ctsN,
   input wire logic dsrN,
   input wire logic dcdN,
   input wire logic riN,
   output var logic dtrN,
   output var logic rtsN,
   // UART core side
   input wire logic txSerial,
   output var logic rxSerial,
   output var logic rxEnable,
   input wire logic overrunEvt,
   input wire logic parityEvt,
   input wire logic framingEvt,
   input wire logic breakEvt,
   input wire logic rxFullIn,
   input wire logic txEmptyIn,
   input wire logic txIdleIn,
   input wire logic flowDtrReq,
   input wire logic flowRtsReq,
   input wire logic statusIrqEn,
   input wire logic rxIrqEn,
   input wire logic txIrqEn,
   output var logic [3:0] modemStatusHi,
   output var logic rxDmaHalt,
   output var logic statusIrq,
   output var logic rxIrq,
   output var logic txIrq,
   output var logic uartResetOut
);
   // ----------------------------------------
   // Bus slave and pin synchronisers
   // ----------------------------------------
   umcls_regs_if bus ();
   logic [4:0] pinSync;

   umcls_axi_slave uSlave (
      .clk(clk),
      .nrst(nrst),
      .awvalid(awvalid),
      .awready(awready),
      .awaddr(awaddr),
      .wvalid(wvalid),
      .wready(wready),
      .wdata(wdata),
      .wstrb(wstrb),
      .bvalid(bvalid),
      .bready(bready),
      .bresp(bresp),
      .arvalid(arvalid),
      .arready(arready),
      .araddr(araddr),
      .rvalid(rvalid),
      .rready(rready),
      .rdata(rdata),
      .rresp(rresp),
      .bus(bus.slave)
   );

   umcls_sync #(.W(5)) uSync (
      .clk(clk),
      .nrst(nrst),
      .d({dcdN, riN, dsrN, ctsN, sin}),
      .q(pinSync)
   );

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [7:0] modemCtrl_reg, modemCtrl_next;
   logic [7:0] flowCtrl_reg, flowCtrl_next;
   logic [3:0] errs_reg, errs_next;
   logic rxFull_reg, txEmpty_reg, txIdle_reg;

   // Soft reset bit restarts the UART state, ORed with the hard reset
   wire uartRst = !nrst || modemCtrl_reg[umcls_pkg::MC_SRST];

   // Write decode
   wire wrModemCtrl = bus.wrEn && bus.wrIdx == umcls_pkg::MODEM_CTRL_IDX;
   wire wrFcr = bus.wrEn && bus.wrIdx == umcls_pkg::FLOW_CTRL_IDX;
   wire wrLineStat = bus.wrEn && bus.wrIdx == umcls_pkg::LINE_STAT_IDX;

   // Control fields
   wire loopOn = modemCtrl_reg[umcls_pkg::MC_LOOP];
   wire rs485On = flowCtrl_reg[umcls_pkg::FC_485];
   wire autoFlow = flowCtrl_reg[umcls_pkg::FC_DTRFL] ||
      flowCtrl_reg[umcls_pkg::FC_RTSFL];
   wire txActive = !txIdle_reg;

   // Next values of the writable registers
   assign modemCtrl_next = wrModemCtrl ? bus.wrData : modemCtrl_reg;
   assign flowCtrl_next = wrFcr ? bus.wrData : flowCtrl_reg;

   // Error flags: set wins over a same-cycle clear, zeros leave flags
   wire [3:0] errEvt = {breakEvt, framingEvt, parityEvt, overrunEvt};
   wire [3:0] errClr = wrLineStat ? bus.wrData[3:0] : 4'h0;
   assign errs_next = (errs_reg & ~errClr) | errEvt;

   // ----------------------------------------
   // Read-back values
   // ----------------------------------------
   wire [7:0] lineStat = {1'b0, txIdle_reg, txEmpty_reg, rxFull_reg,
      errs_reg};
   wire [7:0] modemStat = {modemStatusHi, 4'h0};
   assign bus.rdData =
      bus.rdIdx == umcls_pkg::MODEM_CTRL_IDX ? modemCtrl_reg :
      bus.rdIdx == umcls_pkg::LINE_STAT_IDX ? lineStat :
      bus.rdIdx == umcls_pkg::MODEM_STAT_IDX ? modemStat :
      bus.rdIdx == umcls_pkg::FLOW_CTRL_IDX ? flowCtrl_reg : 8'h00;

   // ----------------------------------------
   // Pin and status next values
   // ----------------------------------------
   // Loop-back: out held high, transmitter feeds receiver
   wire soutNext = loopOn ? umcls_pkg::PIN_IDLE : txSerial;
   wire rxSerialNext = loopOn ? txSerial : pinSync[0];
   // Modem inputs cut off in loop-back; control bits take their place
   wire [3:0] msHiNext = loopOn ?
      {modemCtrl_reg[umcls_pkg::MC_CARRIER],
       modemCtrl_reg[umcls_pkg::MC_RING],
       modemCtrl_reg[umcls_pkg::MC_RTS], modemCtrl_reg[umcls_pkg::MC_DTR]}
      : ~pinSync[4:1];
   // DTR pin: idle in RS-485, flow logic under auto flow, else the bit
   wire dtrNNext = rs485On ? umcls_pkg::PIN_IDLE :
      autoFlow ? !flowDtrReq :
      !modemCtrl_reg[umcls_pkg::MC_DTR];
   // RTS pin: asserted while sending in RS-485
   wire rtsNNext = rs485On ? !txActive :
      autoFlow ? !flowRtsReq :
      !modemCtrl_reg[umcls_pkg::MC_RTS];
   // RS-485 receiver muted while sending unless receiver enable is set
   wire rxEnNext = !(rs485On && !modemCtrl_reg[umcls_pkg::MC_RXEN] &&
      txActive);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Control registers
   always_ff @(posedge clk) begin
      if (uartRst) begin
         modemCtrl_reg <= umcls_pkg::MC_RST;
         flowCtrl_reg <= umcls_pkg::FC_RST;
      end else begin
         modemCtrl_reg <= modemCtrl_next;
         flowCtrl_reg <= flowCtrl_next;
      end
   end

   // Line status flags and sampled levels
   always_ff @(posedge clk) begin
      if (uartRst) begin
         errs_reg <= umcls_pkg::ERR_RST;
         rxFull_reg <= 1'b0;
         txEmpty_reg <= 1'b1;
         txIdle_reg <= 1'b1;
      end else begin
         errs_reg <= errs_next;
         rxFull_reg <= rxFullIn;
         txEmpty_reg <= txEmptyIn;
         txIdle_reg <= txIdleIn && txEmptyIn;
      end
   end

   // Pins toward the line and the UART core
   always_ff @(posedge clk) begin
      if (uartRst) begin
         sout <= umcls_pkg::PIN_IDLE;
         rxSerial <= umcls_pkg::PIN_IDLE;
         dtrN <= umcls_pkg::PIN_IDLE;
         rtsN <= umcls_pkg::PIN_IDLE;
         rxEnable <= 1'b1;
         modemStatusHi <= 4'h0;
      end else begin
         sout <= soutNext;
         rxSerial <= rxSerialNext;
         dtrN <= dtrNNext;
         rtsN <= rtsNNext;
         rxEnable <= rxEnNext;
         modemStatusHi <= msHiNext;
      end
   end

   // DMA halt and interrupt requests
   always_ff @(posedge clk) begin
      if (uartRst) begin
         rxDmaHalt <= 1'b0;
         statusIrq <= 1'b0;
         rxIrq <= 1'b0;
         txIrq <= 1'b0;
      end else begin
         rxDmaHalt <= |errs_reg;
         statusIrq <= statusIrqEn && |errs_reg;
         rxIrq <= rxIrqEn && rxFull_reg;
         txIrq <= txIrqEn && txEmpty_reg;
      end
   end

   // Soft reset seen from outside, cleared by its own reset cycle
   always_ff @(posedge clk) begin
      if (!nrst) begin
         uartResetOut <= 1'b0;
      end else begin
         uartResetOut <= modemCtrl_reg[umcls_pkg::MC_SRST];
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (uartRst);

   sequence s_overrunCaught;
      overrunEvt ##1 errs_reg[0];
   endsequence

   sequence s_loopHeld;
      loopOn [*2];
   endsequence

   property p_loopOut;
      s_loopHeld |=> sout && rxSerial == $past(txSerial);
   endproperty
   a_loopOut: assert property (p_loopOut)
      else $error("Loop-back serial path wrong");

   property p_loopCts;
      s_loopHeld |=> modemStatusHi[0] ==
         $past(modemCtrl_reg[umcls_pkg::MC_DTR]);
   endproperty
   a_loopCts: assert property (p_loopCts)
      else $error("Looped clear-to-send wrong");

   property p_loopDsr;
      s_loopHeld |=> modemStatusHi[1] ==
         $past(modemCtrl_reg[umcls_pkg::MC_RTS]);
   endproperty
   a_loopDsr: assert property (p_loopDsr)
      else $error("Looped set-ready wrong");

   property p_loopRiCd;
      s_loopHeld |=> modemStatusHi[3:2] ==
         {$past(modemCtrl_reg[umcls_pkg::MC_CARRIER]),
          $past(modemCtrl_reg[umcls_pkg::MC_RING])};
   endproperty
   a_loopRiCd: assert property (p_loopRiCd)
      else $error("Looped ring or carrier wrong");

   property p_dtrPin;
      !rs485On && !autoFlow |=>
         dtrN == !$past(modemCtrl_reg[umcls_pkg::MC_DTR]);
   endproperty
   a_dtrPin: assert property (p_dtrPin)
      else $error("DTR pin does not follow control bit");

   property p_rtsPin;
      !rs485On && !autoFlow |=>
         rtsN == !$past(modemCtrl_reg[umcls_pkg::MC_RTS]);
   endproperty
   a_rtsPin: assert property (p_rtsPin)
      else $error("RTS pin does not follow control bit");

   property p_rs485Dtr;
      rs485On |=> dtrN;
   endproperty
   a_rs485Dtr: assert property (p_rs485Dtr)
      else $error("DTR driven in RS-485 mode");

   property p_ovrHalt;
      s_overrunCaught |=> rxDmaHalt && (statusIrq == $past(statusIrqEn));
   endproperty
   a_ovrHalt: assert property (p_ovrHalt)
      else $error("Overrun did not halt DMA or interrupt");

   property p_zeroKeeps;
      errs_reg[1] && wrLineStat && !bus.wrData[1] |=> errs_reg[1];
   endproperty
   a_zeroKeeps: assert property (p_zeroKeeps)
      else $error("Writing zero cleared an error flag");

   property p_oneClears;
      errs_reg[2] && wrLineStat && bus.wrData[2] && !framingEvt
         |=> !errs_reg[2];
   endproperty
   a_oneClears: assert property (p_oneClears)
      else $error("Writing one did not clear an error flag");

   property p_sticky;
      errs_reg[3] && !wrLineStat |=> errs_reg[3];
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("Break flag dropped without a clear");

   property p_bit7Zero;
      bus.rdIdx == umcls_pkg::LINE_STAT_IDX |-> bus.rdData[7] == 1'b0;
   endproperty
   a_bit7Zero: assert property (p_bit7Zero)
      else $error("Reserved status bit set");
endmodule
`default_nettype wire

// >>> umcls_pkg.sv
// Constants and decoding shared by the modem-control and line-status block
// Assumes a 32-bit AXI4-Lite bus with one register per aligned word
package umcls_pkg;
   // ----------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------
   localparam int unsigned IDXW = 16;
   localparam int unsigned ADDRW = 18;
   localparam logic [15:0] FLOW_CTRL_IDX = 16'hffa3;
   localparam logic [15:0] MODEM_CTRL_IDX = 16'hffa4;
   localparam logic [15:0] LINE_STAT_IDX = 16'hffa5;
   localparam logic [15:0] MODEM_STAT_IDX = 16'hffa6;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int unsigned MC_SRST = 0;
   localparam int unsigned MC_RXEN = 1;
   localparam int unsigned MC_LOOP = 2;
   localparam int unsigned MC_DTR = 4;
   localparam int unsigned MC_RTS = 5;
   localparam int unsigned MC_RING = 6;
   localparam int unsigned MC_CARRIER = 7;
   localparam int unsigned FC_RTSFL = 5;
   localparam int unsigned FC_DTRFL = 6;
   localparam int unsigned FC_485 = 7;
   // ----------------------------------------
   // Reset values and bus answers
   // ----------------------------------------
   localparam logic [7:0] MC_RST = 8'h00;
   localparam logic [7:0] FC_RST = 8'h00;
   localparam logic [3:0] ERR_RST = 4'h0;
   localparam logic PIN_IDLE = 1'b1;
   localparam logic [1:0] RESP_OK = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Answers whether an index names a register of this block
   function automatic logic umclsMapped(input logic [15:0] idx);
      return idx == FLOW_CTRL_IDX || idx == MODEM_CTRL_IDX ||
         idx == LINE_STAT_IDX || idx == MODEM_STAT_IDX;
   endfunction
endpackage

// >>> umcls_regs_if.sv
// Register access path between the bus slave and the block core
// Assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface umcls_regs_if;
   logic wrEn;
   logic [15:0] wrIdx;
   logic [7:0] wrData;
   logic [15:0] rdIdx;
   logic [7:0] rdData;
   modport slave (output wrEn, wrIdx, wrData, rdIdx, input rdData);
   modport core (input wrEn, wrIdx, wrData, rdIdx, output rdData);
endinterface
`default_nettype wire

// >>> umcls_sync.sv
// Three-stage pin synchroniser, a change counts once stages two and three
// agree; assumes inputs idle high
`timescale 1ns/1ps
`default_nettype none
module umcls_sync #(
   parameter int W = 5
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output var logic [W-1:0] q
);
   genvar i;
   // One chain per input bit
   generate
      for (i = 0; i < W; i++) begin : gBit
         logic s1, s2, s3;
         always_ff @(posedge clk) begin
            if (!nrst) begin
               s1 <= umcls_pkg::PIN_IDLE;
               s2 <= umcls_pkg::PIN_IDLE;
               s3 <= umcls_pkg::PIN_IDLE;
               q[i] <= umcls_pkg::PIN_IDLE;
            end else begin
               s1 <= d[i];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3) q[i] <= s3;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// >>> umcls_axi_slave.sv
// AXI4-Lite slave for the byte-wide registers
// Assumes one write and one read at a time; data in the low byte
`timescale 1ns/1ps
`default_nettype none
module umcls_axi_slave (
   input wire logic clk,
   input wire logic nrst,
   input wire logic awvalid,
   output var logic awready,
   input wire logic [17:0] awaddr,
   input wire logic wvalid,
   output var logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output var logic bvalid,
   input wire logic bready,
   output var logic [1:0] bresp,
   input wire logic arvalid,
   output var logic arready,
   input wire logic [17:0] araddr,
   output var logic rvalid,
   input wire logic rready,
   output var logic [31:0] rdata,
   output var logic [1:0] rresp,
   umcls_regs_if.slave bus
);
   logic [15:0] awIdx_reg;
   logic [7:0] wByte_reg;
   logic wLane_reg;
   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire doWrite = !awready && !wready && !bvalid;
   wire arIdxOk = umcls_pkg::umclsMapped(araddr[17:2]);
   wire wrOk = umcls_pkg::umclsMapped(awIdx_reg);
   assign bus.wrEn = doWrite && wrOk && wLane_reg;
   assign bus.wrIdx = awIdx_reg;
   assign bus.wrData = wByte_reg;
   assign bus.rdIdx = araddr[17:2];
   // Write channels, taken in either order, answered after both
   always_ff @(posedge clk) begin
      if (!nrst) begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= umcls_pkg::RESP_OK;
         awIdx_reg <= '0;
         wByte_reg <= '0;
         wLane_reg <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            awIdx_reg <= awaddr[17:2];
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
            wByte_reg <= wdata[7:0];
            wLane_reg <= wstrb[0];
         end
         if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= wrOk ? umcls_pkg::RESP_OK : umcls_pkg::RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end
   // Read channel, data captured at the address handshake
   always_ff @(posedge clk) begin
      if (!nrst) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= umcls_pkg::RESP_OK;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= {24'h000000, arIdxOk ? bus.rdData : 8'h00};
         rresp <= arIdxOk ? umcls_pkg::RESP_OK : umcls_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// >>> umcls_modem_model.sv
// Behavioural modem on the far side of the serial and modem pins
// Assumes pins idle high; the bench chooses which lines are asserted
`timescale 1ns/1ps
`default_nettype none
module umcls_modem_model (
   input wire logic dtrN,
   input wire logic rtsN,
   input wire logic sout,
   input wire logic [3:0] assertLines,
   input wire logic sendLow,
   output var logic sin,
   output var logic ctsN,
   output var logic dsrN,
   output var logic riN,
   output var logic dcdN
);
   // Active-low status lines: bit 0 clear-to-send, 1 set-ready, 2 ring,
   // 3 carrier; the data line idles high, as a pulled-up line would
   always_comb begin
      ctsN = ~assertLines[0];
      dsrN = ~assertLines[1];
      riN = ~assertLines[2];
      dcdN = ~assertLines[3];
      sin = ~sendLow;
   end
endmodule
`default_nettype wire

// >>> test_uart_modem_control_line_status.sv
// Self-checking bench for the modem-control and line-status block
// Assumes the design files and the modem model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_uart_modem_control_line_status;
   logic clk = 1'b0, nrst = 1'b0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [17:0] awaddr = 18'h0, araddr = 18'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0, errEvt = 4'h0, lines = 4'h0, msHi;
   logic [1:0] bresp, rresp, resp;
   logic sin, sout, ctsN, dsrN, dcdN, riN, dtrN, rtsN, rxSerial, rxEnable;
   logic txSerial = 1, rxFullIn = 0, txEmptyIn = 1, txIdleIn = 1;
   logic flowDtrReq = 0, flowRtsReq = 0, sendLow = 0;
   logic statusIrqEn = 1, rxIrqEn = 1, txIrqEn = 1;
   logic rxDmaHalt, statusIrq, rxIrq, txIrq, uartResetOut;
   logic [31:0] rd;
   int fails = 0, nTests = 0;
   always #5 clk = ~clk;
   umcls_top umcls_top_inst (.clk(clk), .nrst(nrst), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .sin(sin), .sout(sout), .ctsN(ctsN), .dsrN(dsrN), .dcdN(dcdN),
      .riN(riN), .dtrN(dtrN), .rtsN(rtsN), .txSerial(txSerial),
      .rxSerial(rxSerial), .rxEnable(rxEnable), .overrunEvt(errEvt[0]),
      .parityEvt(errEvt[1]), .framingEvt(errEvt[2]), .breakEvt(errEvt[3]),
      .rxFullIn(rxFullIn), .txEmptyIn(txEmptyIn), .txIdleIn(txIdleIn),
      .flowDtrReq(flowDtrReq), .flowRtsReq(flowRtsReq),
      .statusIrqEn(statusIrqEn), .rxIrqEn(rxIrqEn), .txIrqEn(txIrqEn),
      .modemStatusHi(msHi), .rxDmaHalt(rxDmaHalt), .statusIrq(statusIrq),
      .rxIrq(rxIrq), .txIrq(txIrq), .uartResetOut(uartResetOut));
   umcls_modem_model umcls_modem_model_inst (.dtrN(dtrN), .rtsN(rtsN),
      .sout(sout), .assertLines(lines), .sendLow(sendLow), .sin(sin),
      .ctsN(ctsN), .dsrN(dsrN), .riN(riN), .dcdN(dcdN));
   // ----------------------------------------
   // Shared helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("Compares %0d mismatches %0d", nTests, fails);
      if (fails == 0 && nTests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Waits n edges, then settles to the falling edge for sampling
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   // Bus write; handshakes are judged on values stable since the last edge
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic a, w, b;
      @(posedge clk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      wstrb <= 4'h1;
      bready <= 1'b1;
      do begin
         @(negedge clk);
         a = awvalid & awready;
         w = wvalid & wready;
         b = bvalid & bready;
         resp = bresp;
         @(posedge clk);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end while (!b);
      bready <= 1'b0;
   endtask
   task automatic receive_data_register(input logic [15:0] idx);
      logic a, r;
      @(posedge clk);
      arvalid <= 1'b1;
      araddr <= {idx, 2'b00};
      rready <= 1'b1;
      do begin
         @(negedge clk);
         a = arvalid & arready;
         r = rvalid & rready;
         rd = rdata;
         resp = rresp;
         @(posedge clk);
         if (a) arvalid <= 1'b0;
      end while (!r);
      rready <= 1'b0;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Reset values, read-only status bits and an unmapped place
   task automatic t_reset();
      receive_data_register(umcls_pkg::LINE_STAT_IDX);
      chk(rd, 32'h60);
      receive_data_register(umcls_pkg::MODEM_CTRL_IDX);
      chk(rd, 32'h0);
      wr(umcls_pkg::LINE_STAT_IDX, 8'hf0);
      receive_data_register(umcls_pkg::LINE_STAT_IDX);
      chk(rd, 32'h60);
      receive_data_register(16'h0000);
      chk({30'h0, resp}, {30'h0, umcls_pkg::RESP_SLVERR});
      chk(rd, 32'h0);
      $display("reset test done");
   endtask
   // Control bits drive the pins unless flow control or RS-485 owns them
   task automatic t_pins();
      wr(umcls_pkg::MODEM_CTRL_IDX, 8'h10);
      wt(1);
      chk({dtrN, rtsN}, 2'b01);
      wr(umcls_pkg::MODEM_CTRL_IDX, 8'h30);
      wt(1);
      chk({dtrN, rtsN}, 2'b00);
      wr(umcls_pkg::FLOW_CTRL_IDX, 8'h40);
      wt(1);
      chk(dtrN, 1'b1);
      wr(umcls_pkg::FLOW_CTRL_IDX, 8'h80);
      wt(1);
      chk(dtrN, 1'b1);
      @(posedge clk);
      txIdleIn <= 1'b0;
      wt(3);
      chk({rxEnable, rtsN}, 2'b00);
      wr(umcls_pkg::MODEM_CTRL_IDX, 8'h02);
      wt(2);
      chk(rxEnable, 1'b1);
      @(posedge clk);
      txIdleIn <= 1'b1;
      wr(umcls_pkg::FLOW_CTRL_IDX, 8'h00);
      wr(umcls_pkg::MODEM_CTRL_IDX, 8'h00);
      wt(1);
      chk({dtrN, rtsN}, 2'b11);
      $display("pin test done");
   endtask
   // Loop-back mirrors the control bits and isolates sin, sout and the modem inputs
   task automatic t_loop();
      wr(umcls_pkg::MODEM_CTRL_IDX, 8'hf4);
      sendLow <= 1'b1;
      txSerial <= 1'b0;
      wt(8);
      chk(msHi, 4'hf);
      chk({sout, rxSerial}, 2'b10);
      receive_data_register(umcls_pkg::MODEM_STAT_IDX);
      chk(rd, 32'hf0);
      txSerial <= 1'b1;
      lines <= 4'hf;
      wr(umcls_pkg::MODEM_CTRL_IDX, 8'h04);
      wt(8);
      chk({msHi, rxSerial}, 5'h01);
      @(posedge clk);
      lines <= 4'h5;
      wr(umcls_pkg::MODEM_CTRL_IDX, 8'h00);
      wt(8);
      chk({msHi, rxSerial}, 5'h0a);
      sendLow <= 1'b0;
      lines <= 4'h0;
      $display("loop test done");
   endtask
   // Each error flag sets, halts, holds, and clears only by a one
   task automatic t_errors();
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         errEvt <= 4'h1 << i;
         @(posedge clk);
         errEvt <= 4'h0;
         wt(3);
         chk({rxDmaHalt, statusIrq}, 2'b11);
         wr(umcls_pkg::LINE_STAT_IDX, 8'h00);
         receive_data_register(umcls_pkg::LINE_STAT_IDX);
         chk(rd, 32'h60 | (32'h1 << i));
         wr(umcls_pkg::LINE_STAT_IDX, 8'h01 << i);
         receive_data_register(umcls_pkg::LINE_STAT_IDX);
         chk(rd, 32'h60);
         wt(2);
         chk({rxDmaHalt, statusIrq}, 2'b00);
      end
      @(posedge clk);
      statusIrqEn <= 1'b0;
      errEvt <= 4'h9;
      @(posedge clk);
      errEvt <= 4'h0;
      wt(3);
      chk({rxDmaHalt, statusIrq}, 2'b10);
      wr(umcls_pkg::LINE_STAT_IDX, 8'h0f);
      statusIrqEn <= 1'b1;
      $display("error test done");
   endtask
   // Receive-full, transmit-empty and idle flags with their interrupts
   task automatic t_levels();
      rxFullIn <= 1'b1;
      txEmptyIn <= 1'b0;
      txIdleIn <= 1'b0;
      wt(3);
      chk({rxIrq, txIrq}, 2'b10);
      receive_data_register(umcls_pkg::LINE_STAT_IDX);
      chk(rd, 32'h10);
      rxFullIn <= 1'b0;
      txEmptyIn <= 1'b1;
      rxIrqEn <= 1'b0;
      wt(3);
      chk({rxIrq, txIrq}, 2'b01);
      receive_data_register(umcls_pkg::LINE_STAT_IDX);
      chk(rd, 32'h20);
      txIdleIn <= 1'b1;
      rxIrqEn <= 1'b1;
      $display("level test done");
   endtask
   // Soft reset clears control, flow and error state; control and flow then read back zero
   task automatic t_soft();
      wr(umcls_pkg::FLOW_CTRL_IDX, 8'h80);
      errEvt <= 4'h2;
      @(posedge clk);
      errEvt <= 4'h0;
      wr(umcls_pkg::MODEM_CTRL_IDX, 8'h31);
      @(negedge clk);
      chk({uartResetOut, dtrN, rtsN, rxDmaHalt}, 4'he);
      wt(1);
      chk(uartResetOut, 1'b0);
      receive_data_register(umcls_pkg::FLOW_CTRL_IDX);
      chk(rd, 32'h0);
      receive_data_register(umcls_pkg::LINE_STAT_IDX);
      chk(rd, 32'h60);
      receive_data_register(umcls_pkg::MODEM_CTRL_IDX);
      chk(rd, 32'h0);
      $display("soft reset test done");
   endtask
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_pins();
      t_loop();
      t_errors();
      t_levels();
      t_soft();
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      finish_test();
   end
endmodule
`default_nettype wire
